/* File: core/pcrs_pkg.sv */
/*
  Shared constants and types of the start-up, clocking and reset sequencer.
  Assumes a 10 MHz sequencer clock; all timing counts derive from its period.
*/
package pcrs_pkg;

  // Sequencer clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 100;

  // Least time the hardware reset pin must be low to reset registers.
  localparam int PIN_RESET_MIN_NS  = 1000;
  localparam int PIN_RESET_MIN_CYC = (PIN_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Nominal clock rates of the transceiver clocking scheme.
  localparam int REF_CLK_MHZ  = 13;
  localparam int PLL_OUT_MHZ  = 480;
  localparam int LINK_CLK_MHZ = 60;
  localparam int PLL_TO_LINK_DIV = PLL_OUT_MHZ / LINK_CLK_MHZ;

  // Defaults of the sequencer parameters.
  localparam int LOCK_EDGES_DEF = 16;
  localparam int REF_STOP_CYC_DEF = 8;

  // Reset value of the bus direction output.
  localparam logic DIR_RST = 1'b1;

  // Encoding of the UART supply level selection field.
  localparam logic [1:0] REG_SEL_3V3  = 2'h0;
  localparam logic [1:0] REG_SEL_3V0  = 2'h1;
  localparam logic [1:0] REG_SEL_2V75 = 2'h2;
  localparam logic [1:0] REG_SEL_2V5  = 2'h3;

  // Nominal regulator output in millivolts for each selection.
  localparam logic [11:0] MV_3V3  = 12'hce4;
  localparam logic [11:0] MV_3V0  = 12'hbb8;
  localparam logic [11:0] MV_2V75 = 12'habe;
  localparam logic [11:0] MV_2V5  = 12'h9c4;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_LOCK = 4'h2,
    ST_RUN  = 4'h4,
    ST_LOWP = 4'h8
  } pcrs_state_t;

endpackage

/* File: core/pcrs_refmon.sv */
/*
  Reference clock monitor: flags each rising edge and a stopped reference.
  Assumes its input is already synchronised to the sequencer clock.
*/
`timescale 1ns/10ps
module pcrs_refmon #(
  parameter int STOP_CYC = 8
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Synchronised reference clock level.
  input  wire logic ref_i,
  // Edge pulse and stop flag.
  output logic      ref_rise_o,
  output logic      ref_stopped_o
);

  logic       ref_prev_reg;
  logic [7:0] idle_cnt_reg;

  // Only the rising edge counts; the falling edge is ignored.
  assign ref_rise_o = ref_i & ~ref_prev_reg; // R3

  // Previous sample for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_i;
    end
  end

  // Cycles since the last rising edge, saturating at the stop limit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_reg  <= 8'h00;
      ref_stopped_o <= 1'b1;
    end else if (ref_rise_o) begin
      idle_cnt_reg  <= 8'h00;
      ref_stopped_o <= 1'b0;
    end else if (idle_cnt_reg == 8'(STOP_CYC)) begin
      ref_stopped_o <= 1'b1;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end
  end

endmodule

/* File: core/pcrs_sync.sv */
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level or a clock slower than half the sampling rate.
*/
`timescale 1ns/10ps
module pcrs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

/* File: core/pcrs_top.sv */
/*
  Start-up, clocking and reset sequencer of a transceiver with a low pin
  count link. It holds the bus direction high until the PLL model has locked,
  gates the link clock, handles low power entry and wake-up, produces the
  register default load and state machine reset, and picks the regulator level.
  Assumes a 10 MHz sequencer clock that runs whenever the core supply is up,
  and a reference clock pin scaled so that two flops can sample it.

  // Summary of operation
  // (R1) PLL multiplies the reference into one 480 MHz clock for transmit and receive.
  // (R2) Link clock at 60 MHz comes from the reference, no phase alignment needed.
  // (R3) Only rising edges of the reference clock are used.
  // (R4) Direction drops once locked; the link waits for that before transactions.
  // (R5) Direction stays high from reset release until PLL lock.
  // (R6) Leave reset only with power-on reset high and reset pin high.
  // (R7) Late reference clock after pin release delays start by the same amount.
  // (R8) While reset pin is low, no start-up and no operating current.
  // (R9) Pin low for at least 1 us resets registers and all state machines.
  // (R10) Register defaults load whenever the 1.8 V core supply comes up.
  // (R11) Link may stop the reference in low power only after its last write.
  // (R12) Asserting stop leaves low power mode.
  // (R13) Link restarts the reference together with stop for fastest wake-up.
  // (R14) Reference stopping while running loses lock; link clock drops to minimum.
  // (R15) Host links set automatic resume so the transceiver resumes by itself.
  // (R16) Cable powered device sits in low power until bus voltage returns.
  // (R17) In UART mode the regulator level follows the two-bit selection field.
  // (R18) Selection 01 is 3.0 V, 10 is 2.75 V, 11 is 2.5 V, else 3.3 V.
*/
`timescale 1ns/10ps
module pcrs_top #(
  parameter int LOCK_EDGES   = pcrs_pkg::LOCK_EDGES_DEF,
  parameter int REF_STOP_CYC = pcrs_pkg::REF_STOP_CYC_DEF
) (
  // Clock and reset.
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  // Pins and supply monitor, all asynchronous.
  input  wire logic        REF_CLOCK_IN_I,
  input  wire logic        HW_RESET_PIN_N_I,
  input  wire logic        CORE_SUPPLY_GOOD_I,
  input  wire logic        STP_I,
  // Mode levels from the register file, same clock.
  input  wire logic        LOW_POWER_REQ_I,
  input  wire logic        CARKIT_MODE_I,
  input  wire logic        UART_MODE_I,
  input  wire logic [1:0]  UART_SUPPLY_LEVEL_SEL_I,
  // Link facing status.
  output logic             DIR_O,
  output logic             LINK_CLOCK_RUN_O,
  output logic             LINK_CLOCK_SLOW_O,
  output logic             PLL_LOCKED_O,
  output logic             LOW_POWER_O,
  // Core control.
  output logic             OPER_CURRENT_EN_O,
  output logic             SM_RESET_O,
  output logic             REG_DEFAULTS_LOAD_O,
  output logic             WAKE_O,
  // Regulator control.
  output logic [1:0]       REG_LEVEL_O,
  output logic [11:0]      REG_MILLIVOLT_O
);

  pcrs_pkg::pcrs_state_t state_reg;
  pcrs_pkg::pcrs_state_t state_next;
  logic [3:0]  pins_s;
  logic        ref_s;
  logic        pin_s;
  logic        core_s;
  logic        stp_s;
  logic        stp_prev_reg;
  logic        stp_rise;
  logic        ref_rise;
  logic        ref_stopped;
  logic [3:0]  pin_low_cnt_reg;
  logic        pin_low_long;
  logic        hold_reset;
  logic        lowp_req;
  logic        lowp_prev_reg;
  logic        lowp_rise;
  logic [7:0]  lock_cnt_reg;
  logic        lock_done;
  logic [1:0]  level_next;

  // Maps a regulator selection to its nominal output in millivolts.
  function automatic logic [11:0] level_mv(input logic [1:0] sel);
    case (sel)
      pcrs_pkg::REG_SEL_3V0:  level_mv = pcrs_pkg::MV_3V0;
      pcrs_pkg::REG_SEL_2V75: level_mv = pcrs_pkg::MV_2V75;
      pcrs_pkg::REG_SEL_2V5:  level_mv = pcrs_pkg::MV_2V5;
      default:                level_mv = pcrs_pkg::MV_3V3;
    endcase
  endfunction

  // All pin and supply inputs pass two flops first.
  pcrs_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .async_i ({STP_I, CORE_SUPPLY_GOOD_I, HW_RESET_PIN_N_I, REF_CLOCK_IN_I}),
    .sync_o  (pins_s)
  );

  assign ref_s  = pins_s[0];
  assign pin_s  = pins_s[1];
  assign core_s = pins_s[2];
  assign stp_s  = pins_s[3];

  // Reference edge and stop detection.
  pcrs_refmon #(
    .STOP_CYC (REF_STOP_CYC)
  ) u_refmon (
    .clk_i         (CLOCK_I),
    .rst_i         (SYS_RST_I),
    .ref_i         (ref_s),
    .ref_rise_o    (ref_rise),
    .ref_stopped_o (ref_stopped)
  );

  // Length of the current low phase of the reset pin, saturating.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || pin_s) begin
      pin_low_cnt_reg <= 4'h0;
    end else if (!pin_low_long) begin
      pin_low_cnt_reg <= pin_low_cnt_reg + 4'h1;
    end
  end

  // A long enough low phase, or a missing core supply, resets everything.
  assign pin_low_long = (pin_low_cnt_reg == 4'(pcrs_pkg::PIN_RESET_MIN_CYC)); // R9
  assign hold_reset   = ~core_s | pin_low_long; // R10

  // State machine reset and the default load pulse at its release.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      SM_RESET_O          <= 1'b1;
      REG_DEFAULTS_LOAD_O <= 1'b0;
    end else begin
      SM_RESET_O          <= hold_reset; // R9
      REG_DEFAULTS_LOAD_O <= SM_RESET_O & ~hold_reset; // R10
    end
  end

  // Edge detectors for stop and for the low power request.
  assign lowp_req  = LOW_POWER_REQ_I | CARKIT_MODE_I;
  assign stp_rise  = stp_s & ~stp_prev_reg;
  assign lowp_rise = lowp_req & ~lowp_prev_reg;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      stp_prev_reg  <= 1'b0;
      lowp_prev_reg <= 1'b0;
    end else begin
      stp_prev_reg  <= stp_s;
      lowp_prev_reg <= lowp_req;
    end
  end

  // Lock is declared after a run of rising reference edges.
  assign lock_done = ref_rise && (lock_cnt_reg == 8'(LOCK_EDGES - 1)); // R1

  // Edge counter of the PLL model; a stopped reference restarts it.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || state_reg != pcrs_pkg::ST_LOCK || ref_stopped) begin
      lock_cnt_reg <= 8'h00; // R7
    end else if (ref_rise) begin
      lock_cnt_reg <= lock_cnt_reg + 8'h01; // R3
    end
  end

  // Next state of the sequencer.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pcrs_pkg::ST_OFF: begin
        if (pin_s && core_s) begin
          state_next = pcrs_pkg::ST_LOCK; // R6
        end
      end
      pcrs_pkg::ST_LOCK: begin
        if (lock_done) begin
          state_next = pcrs_pkg::ST_RUN; // R4
        end
      end
      pcrs_pkg::ST_RUN: begin
        if (ref_stopped) begin
          state_next = pcrs_pkg::ST_LOCK; // R14
        end else if (lowp_rise) begin
          state_next = pcrs_pkg::ST_LOWP;
        end
      end
      pcrs_pkg::ST_LOWP: begin
        if (stp_rise) begin
          state_next = pcrs_pkg::ST_LOCK; // R12
        end
      end
      default: begin
        state_next = pcrs_pkg::ST_OFF;
      end
    endcase
    if (!pin_s || !core_s) begin
      state_next = pcrs_pkg::ST_OFF; // R8
    end
  end

  // Sequencer state register.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_reg <= pcrs_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Lock flag and the slow link clock after a lost reference.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      PLL_LOCKED_O      <= 1'b0;
      LINK_CLOCK_SLOW_O <= 1'b0;
    end else begin
      PLL_LOCKED_O <= (state_next == pcrs_pkg::ST_RUN);
      if (state_next == pcrs_pkg::ST_OFF || state_next == pcrs_pkg::ST_RUN) begin
        LINK_CLOCK_SLOW_O <= 1'b0;
      end else if (state_reg == pcrs_pkg::ST_RUN && ref_stopped) begin
        LINK_CLOCK_SLOW_O <= 1'b1; // R14
      end
    end
  end

  // Link clock gate, low power flag, wake pulse and operating current.
  // The gate takes the slow flag's new value into account, so that the link
  // clock does not stop for one cycle on the edge where the reference is lost.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      LINK_CLOCK_RUN_O  <= 1'b0;
      LOW_POWER_O       <= 1'b0;
      WAKE_O            <= 1'b0;
      OPER_CURRENT_EN_O <= 1'b0;
    end else begin
      LINK_CLOCK_RUN_O  <= (state_next == pcrs_pkg::ST_RUN) ||
                           (state_next == pcrs_pkg::ST_LOCK &&
                            (LINK_CLOCK_SLOW_O ||
                             (state_reg == pcrs_pkg::ST_RUN && ref_stopped))); // R2 R14
      LOW_POWER_O       <= (state_next == pcrs_pkg::ST_LOWP); // R11
      WAKE_O            <= (state_reg == pcrs_pkg::ST_LOWP) &&
                           (state_next == pcrs_pkg::ST_LOCK); // R13
      OPER_CURRENT_EN_O <= (state_next != pcrs_pkg::ST_OFF); // R8
    end
  end

  // Direction is high in every state but normal running.
  assign DIR_O = (state_reg == pcrs_pkg::ST_RUN) ? ~pcrs_pkg::DIR_RST : pcrs_pkg::DIR_RST; // R5

  // Regulator level: the selection in UART mode, the standard level otherwise.
  assign level_next = UART_MODE_I ? UART_SUPPLY_LEVEL_SEL_I : pcrs_pkg::REG_SEL_3V3; // R17

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      REG_LEVEL_O     <= pcrs_pkg::REG_SEL_3V3;
      REG_MILLIVOLT_O <= pcrs_pkg::MV_3V3;
    end else begin
      REG_LEVEL_O     <= level_next;
      REG_MILLIVOLT_O <= level_mv(level_next); // R18
    end
  end

  // Checks on the sequencing.
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);

  dir_until_lock_a: assert property (state_reg != pcrs_pkg::ST_RUN |-> DIR_O) // R5
    else $error("Direction low before lock.");

  dir_drop_lock_a: assert property ($rose(PLL_LOCKED_O) |-> !DIR_O ##1 $past(lock_done, 2)) // R4
    else $error("Direction not dropped on lock.");

  pin_low_off_a: assert property (!pin_s |=> state_reg == pcrs_pkg::ST_OFF
                                  && !OPER_CURRENT_EN_O) // R8
    else $error("Device active while reset pin low.");

  start_needs_both_a: assert property ($past(state_reg) == pcrs_pkg::ST_OFF
                                       && state_reg != pcrs_pkg::ST_OFF
                                       |-> $past(pin_s) && $past(core_s)) // R6
    else $error("Start without both resets released.");

  long_low_reset_a: assert property (pin_low_cnt_reg == 4'(pcrs_pkg::PIN_RESET_MIN_CYC - 1)
                                     && !pin_s |=> ##1 SM_RESET_O) // R9
    else $error("Long reset pin low did not reset state machines.");

  release_load_a: assert property ($fell(SM_RESET_O) |-> REG_DEFAULTS_LOAD_O) // R9
    else $error("No default load at reset release.");

  supply_up_load_a: assert property ($rose(core_s) && !pin_low_long && SM_RESET_O
                                     |=> REG_DEFAULTS_LOAD_O ##1 !REG_DEFAULTS_LOAD_O) // R10
    else $error("Core supply rise did not load defaults once.");

  ref_stop_slow_a: assert property (state_reg == pcrs_pkg::ST_RUN && ref_stopped
                                    && pin_s && core_s
                                    |=> LINK_CLOCK_SLOW_O && !PLL_LOCKED_O && DIR_O
                                    && LINK_CLOCK_RUN_O) // R14
    else $error("Lost reference not handled.");

  stp_wake_a: assert property (state_reg == pcrs_pkg::ST_LOWP && stp_rise && pin_s && core_s
                               |=> state_reg == pcrs_pkg::ST_LOCK && WAKE_O) // R12
    else $error("Stop did not leave low power.");

  lock_by_edge_a: assert property ($rose(PLL_LOCKED_O) |-> $past(ref_rise)
                                   && $past(lock_cnt_reg) == 8'(LOCK_EDGES - 1)) // R7
    else $error("Lock without enough reference edges.");

  uart_level_a: assert property (UART_MODE_I |=> REG_LEVEL_O == $past(UART_SUPPLY_LEVEL_SEL_I)
                                 && REG_MILLIVOLT_O == level_mv(REG_LEVEL_O)) // R17
    else $error("UART regulator level not followed.");

  std_level_a: assert property (!UART_MODE_I |=> REG_MILLIVOLT_O == pcrs_pkg::MV_3V3) // R18
    else $error("Standard regulator level not used.");

endmodule

/* File: verif/pcrs_link_model.sv */
/*
  Link controller model: reference clock, reset pin and stop pin.
  Assumes the bench clock; outputs change just after its falling edge.
*/
`timescale 1ns/10ps
module pcrs_link_model #(
  parameter int REF_HALF = 2
) (
  // Clock and controls from the bench.
  input  wire logic clk_i,
  input  wire logic ref_run_i,
  input  wire logic pin_n_i,
  input  wire logic wake_i,
  // Device status.
  input  wire logic dir_i,
  // Pins toward the device.
  output logic      ref_clock_o,
  output logic      hw_reset_pin_n_o,
  output logic      stp_o,
  output logic      link_ready_o
);
  int half_cnt = 0;

  // The reference runs only when enabled or waking and rests low between uses.
  // To wake, it raises stop and restarts the reference together with it.
  always @(negedge clk_i) begin
    hw_reset_pin_n_o <= pin_n_i;
    stp_o            <= wake_i;
    if (ref_run_i || wake_i) begin
      half_cnt = half_cnt + 1;
      if (half_cnt >= REF_HALF) begin
        half_cnt = 0;
        ref_clock_o <= ~ref_clock_o;
      end
    end else begin
      half_cnt = 0;
      ref_clock_o <= 1'b0;
    end
  end

  // The link starts bus traffic only once direction has dropped.
  assign link_ready_o = hw_reset_pin_n_o & ~dir_i;

  // Pins start quiet with the device held in reset.
  initial begin
    ref_clock_o      = 1'b0;
    hw_reset_pin_n_o = 1'b0;
    stp_o            = 1'b0;
  end
endmodule

/* File: verif/pcrs_top_bench.sv */
/*
  Self-checking bench of the start-up sequencer with a link model beside it.
  Assumes small lock and stop counts and a reference of four clock periods.
*/
`timescale 1ns/10ps
module pcrs_top_bench;
  localparam int LOCK_N = 4;
  logic        CLOCK_I = 1'b0;
  logic        SYS_RST_I, REF_CLOCK_IN_I, HW_RESET_PIN_N_I, CORE_SUPPLY_GOOD_I, STP_I;
  logic        LOW_POWER_REQ_I, CARKIT_MODE_I, UART_MODE_I;
  logic [1:0]  UART_SUPPLY_LEVEL_SEL_I;
  logic        DIR_O, LINK_CLOCK_RUN_O, LINK_CLOCK_SLOW_O, PLL_LOCKED_O, LOW_POWER_O;
  logic        OPER_CURRENT_EN_O, SM_RESET_O, REG_DEFAULTS_LOAD_O, WAKE_O;
  logic [1:0]  REG_LEVEL_O;
  logic [11:0] REG_MILLIVOLT_O;
  logic        ref_run, pin_n, wake, link_ready;
  int          err_count = 0;
  int          n_checks = 0;
  int          loads = 0;
  int          wakes = 0;
  int          rises = 0;
  int          n;

  pcrs_top #(
    .LOCK_EDGES   (LOCK_N),
    .REF_STOP_CYC (6)
  ) pcrs_top_inst (
    .CLOCK_I                 (CLOCK_I),
    .SYS_RST_I               (SYS_RST_I),
    .REF_CLOCK_IN_I          (REF_CLOCK_IN_I),
    .HW_RESET_PIN_N_I        (HW_RESET_PIN_N_I),
    .CORE_SUPPLY_GOOD_I      (CORE_SUPPLY_GOOD_I),
    .STP_I                   (STP_I),
    .LOW_POWER_REQ_I         (LOW_POWER_REQ_I),
    .CARKIT_MODE_I           (CARKIT_MODE_I),
    .UART_MODE_I             (UART_MODE_I),
    .UART_SUPPLY_LEVEL_SEL_I (UART_SUPPLY_LEVEL_SEL_I),
    .DIR_O                   (DIR_O),
    .LINK_CLOCK_RUN_O        (LINK_CLOCK_RUN_O),
    .LINK_CLOCK_SLOW_O       (LINK_CLOCK_SLOW_O),
    .PLL_LOCKED_O            (PLL_LOCKED_O),
    .LOW_POWER_O             (LOW_POWER_O),
    .OPER_CURRENT_EN_O       (OPER_CURRENT_EN_O),
    .SM_RESET_O              (SM_RESET_O),
    .REG_DEFAULTS_LOAD_O     (REG_DEFAULTS_LOAD_O),
    .WAKE_O                  (WAKE_O),
    .REG_LEVEL_O             (REG_LEVEL_O),
    .REG_MILLIVOLT_O         (REG_MILLIVOLT_O)
  );

  pcrs_link_model pcrs_link_model_inst (
    .clk_i(CLOCK_I), .ref_run_i(ref_run), .pin_n_i(pin_n), .wake_i(wake),
    .dir_i(DIR_O), .ref_clock_o(REF_CLOCK_IN_I), .hw_reset_pin_n_o(HW_RESET_PIN_N_I),
    .stp_o(STP_I), .link_ready_o(link_ready));

  // Clock of 100 ns period.
  always #50 CLOCK_I = ~CLOCK_I;

  // Pulse counters and the count of reference rises seen before lock.
  always @(posedge CLOCK_I) begin
    if (REG_DEFAULTS_LOAD_O === 1'b1) loads++;
    if (WAKE_O === 1'b1) wakes++;
  end
  always @(posedge REF_CLOCK_IN_I) begin
    if (DIR_O === 1'b1) rises++;
  end

  // Expected regulator output from the mode and the selection.
  function automatic logic [11:0] mv_model(input logic mode, input logic [1:0] sel);
    if (!mode) return 12'hce4;
    case (sel)
      2'h1: return 12'hbb8;
      2'h2: return 12'habe;
      2'h3: return 12'h9c4;
      default: return 12'hce4;
    endcase
  endfunction

  // Compares one value and counts it.
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Waits a bounded time for direction to drop.
  task automatic wait_dir(input int limit);
    int k;
    k = 0;
    while (DIR_O !== 1'b0 && k < limit) begin
      @(negedge CLOCK_I);
      k++;
    end
    check("dir_drop", DIR_O, 1'b0);
    check("pll_locked", PLL_LOCKED_O, 1'b1);
  endtask

  // Enters low power by request or carkit, stops the reference, wakes by stop.
  // The plain request stands for a link that parks a cable powered device.
  task automatic low_power(input logic carkit);
    int w;
    w = wakes;
    if (carkit) CARKIT_MODE_I <= 1'b1;
    else LOW_POWER_REQ_I <= 1'b1;
    repeat (3) @(negedge CLOCK_I);
    check("low_power", LOW_POWER_O, 1'b1);
    check("dir_lowp", DIR_O, 1'b1);
    ref_run <= 1'b0;
    repeat (20) @(negedge CLOCK_I);
    check("lowp_hold", LOW_POWER_O, 1'b1);
    wake <= 1'b1;
    CARKIT_MODE_I <= 1'b0;
    LOW_POWER_REQ_I <= 1'b0;
    repeat (6) @(negedge CLOCK_I);
    check("lowp_exit", LOW_POWER_O, 1'b0);
    check("wake_pulse", 12'(wakes - w), 12'h001);
    ref_run <= 1'b1;
    wake <= 1'b0;
    wait_dir(200);
    $display("test low_power carkit=%0d done", carkit);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    #(100 * 10000);
    err_count++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    {SYS_RST_I, CORE_SUPPLY_GOOD_I, LOW_POWER_REQ_I, CARKIT_MODE_I, UART_MODE_I} = 5'h10;
    UART_SUPPLY_LEVEL_SEL_I = 2'h0;
    {ref_run, pin_n, wake} = 3'h0;
    n = $urandom(32'h28d4);
    repeat (12) @(negedge CLOCK_I);
    check("dir_rst", DIR_O, 1'b1);
    check("smr_rst", SM_RESET_O, 1'b1);
    check("mv_rst", REG_MILLIVOLT_O, 12'hce4);
    SYS_RST_I <= 1'b0;
    CORE_SUPPLY_GOOD_I <= 1'b1;
    pin_n <= 1'b1;
    repeat (40) @(negedge CLOCK_I);
    check("dir_no_ref", DIR_O, 1'b1);
    check("load_up", 12'(loads >= 1), 12'h001);
    rises = 0;
    ref_run <= 1'b1;
    wait_dir(200);
    check("lock_rises", 12'(rises >= LOCK_N && rises <= LOCK_N + 2), 12'h001);
    check("clk_run", LINK_CLOCK_RUN_O, 1'b1);
    check("link_ready", link_ready, 1'b1);
    $display("test start_up done");
    low_power(1'b0);
    low_power(1'b1);
    ref_run <= 1'b0;
    repeat (15) @(negedge CLOCK_I);
    check("slow", LINK_CLOCK_SLOW_O, 1'b1);
    check("dir_lost", DIR_O, 1'b1);
    check("clk_slow_run", LINK_CLOCK_RUN_O, 1'b1);
    ref_run <= 1'b1;
    wait_dir(200);
    check("slow_clear", LINK_CLOCK_SLOW_O, 1'b0);
    $display("test ref_loss done");
    pin_n <= 1'b0;
    repeat (5) @(negedge CLOCK_I);
    check("oper_off", OPER_CURRENT_EN_O, 1'b0);
    check("dir_pin", DIR_O, 1'b1);
    pin_n <= 1'b1;
    repeat (3) @(negedge CLOCK_I);
    check("smr_short", SM_RESET_O, 1'b0);
    wait_dir(200);
    pin_n <= 1'b0;
    repeat (16) @(negedge CLOCK_I);
    check("smr_long", SM_RESET_O, 1'b1);
    n = loads;
    pin_n <= 1'b1;
    repeat (8) @(negedge CLOCK_I);
    check("load_pin", 12'(loads > n), 12'h001);
    wait_dir(200);
    CORE_SUPPLY_GOOD_I <= 1'b0;
    repeat (5) @(negedge CLOCK_I);
    check("smr_supply", SM_RESET_O, 1'b1);
    n = loads;
    CORE_SUPPLY_GOOD_I <= 1'b1;
    repeat (8) @(negedge CLOCK_I);
    check("load_supply", 12'(loads > n), 12'h001);
    wait_dir(200);
    $display("test resets done");
    for (int i = 0; i < 28; i++) begin
      UART_MODE_I <= (i < 4) ? 1'b1 : 1'($urandom);
      UART_SUPPLY_LEVEL_SEL_I <= (i < 4) ? 2'(i) : 2'($urandom);
      @(negedge CLOCK_I);
      check("mv", REG_MILLIVOLT_O, mv_model(UART_MODE_I, UART_SUPPLY_LEVEL_SEL_I));
      check("lvl", REG_LEVEL_O, UART_MODE_I ? UART_SUPPLY_LEVEL_SEL_I : 2'h0);
    end
    $display("test regulator done");
    print_verdict();
  end
endmodule
